// ==== rtl/usic_top.sv ====
// How it works
// - Clock-stable flag stays low after reset, or after a wake with both channels asleep, until the settle count completes.
// - Clock-stable flag is counter based; meaningless with an external clock source.
// - Forced sleep gates the channel clock; oscillator and PLL stop only with both channels asleep; registers stay accessible.
// - Config A bit 5 set enters forced sleep; cleared leaves it.
// - Config A bit 6 arms automatic sleep for the channel.
// - Auto sleep needs empty FIFOs, no pending interrupt, 65,536 idle characters.
// - Automatic sleep gates exactly the same blocks as forced sleep.
// - Any edge on GPIO, RX or CTS input wakes the channel from automatic sleep at once.
// - Clearing config A bit 6 leaves automatic sleep and disarms it.
// - Each channel sleeps alone; its clock is gated, shared clocking keeps running.
// - With both channels asleep the shared clock generator is switched off.
// - While reset is low registers are held at reset, clock enables stay on and host accesses are ignored.
// - Reset release gives a full reset; host must reprogram all configuration.
// - Interrupt output is low while an enabled interrupt is pending.
// - Interrupt output asserts only when a top interrupt enable bit is set.
// - Top status bits 2:0 summarise line, special-character and general events.
// - Every source bit has an enable bit; all enables reset cleared.
// - Reading top status while pending clears it; details do not re-raise.
// - Special-character and general event registers clear on read.
// - Line status bits follow their conditions; reading leaves them unchanged.
// - Other registers reset to zero and are read/write.
// - Top status resets 0x60, frame format 0x05, general status nonzero.
`timescale 1ns/1ps
`default_nettype none
module usic_top #(
  parameter int unsigned IDLE_CHARS = 65536,
  parameter int unsigned SETTLE_CYC = 1024
) (
  // Clock and reset.
  input  wire logic                      clk,
  input  wire logic                      resetn,
  // Register port from the host serial interface.
  input  wire logic                      reg_ch,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  input  wire logic [3:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  output logic      [7:0]                reg_rdata,
  // Holding data towards and from the FIFOs.
  output logic      [usic_pkg::NCH-1:0]  tx_wr,
  output logic      [7:0]                tx_data,
  input  wire logic [usic_pkg::NCH-1:0][7:0] rx_data,
  // Channel pins watched for activity.
  input  wire logic [usic_pkg::NCH-1:0]  rx_pin,
  input  wire logic [usic_pkg::NCH-1:0]  cts_pin,
  input  wire logic [usic_pkg::NCH-1:0][3:0] gpio_pin,
  // Event and condition inputs from the channel data paths.
  input  wire logic [usic_pkg::NCH-1:0][4:0] top_evt,
  input  wire logic [usic_pkg::NCH-1:0][5:0] line_cond,
  input  wire logic [usic_pkg::NCH-1:0][5:0] spc_evt,
  input  wire logic [usic_pkg::NCH-1:0][3:0] gpi_evt,
  input  wire logic [usic_pkg::NCH-1:0]  tx_empty_evt,
  input  wire logic [usic_pkg::NCH-1:0]  fifos_empty,
  input  wire logic [usic_pkg::NCH-1:0]  baud_tick,
  // Clock gating and interrupt.
  output logic      [usic_pkg::NCH-1:0]  ch_clk_en,
  output logic                           shared_clk_en,
  output logic                           irq_n
);

  localparam int unsigned CW = $clog2(IDLE_CHARS + 1);
  localparam int unsigned SW = $clog2(SETTLE_CYC + 1);

  logic [usic_pkg::NCH-1:0]      asleep;
  logic [usic_pkg::NCH-1:0]      ch_irq;
  logic [usic_pkg::NCH-1:0][7:0] rd_ch;
  logic                          settled;

  ////////////////////////////////////////////////////////////////////////////
  // Shared clock generator and its settle counter.

  logic [SW-1:0] settle_r;
  logic [SW-1:0] settle_nxt;

  always_comb begin
    shared_clk_en = ~&asleep;
    settle_nxt    = settle_r;
    if (!shared_clk_en) begin
      settle_nxt = '0;
    end else if (settle_r != SW'(SETTLE_CYC)) begin
      settle_nxt = settle_r + SW'(1);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      settle_r <= '0;
    end else begin
      settle_r <= settle_nxt;
    end
  end

  assign settled = (settle_r == SW'(SETTLE_CYC));

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel registers, interrupt tree and power state.

  for (genvar c = 0; c < usic_pkg::NCH; c++) begin : g_ch
    logic                wsel;
    logic                rsel;
    logic [7:0]          top_interrupt_enable_r, top_interrupt_enable_nxt, lsren_r, lsren_nxt, spen_r, spen_nxt;
    logic [7:0]          stsen_r, stsen_nxt, operating_config_a_r, operating_config_a_nxt, operating_config_b_r, operating_config_b_nxt;
    logic [7:0]          lcr_r, lcr_nxt, rxto_r, rxto_nxt, hdpx_r, hdpx_nxt;
    logic [7:0]          isr_r, isr_nxt, lsr_r, lsr_nxt, spc_r, spc_nxt, sts_r, sts_nxt;
    logic [7:0]          sts_view;
    logic [2:0]          sum_r, sum_nxt;
    usic_pkg::usic_pwr_t pwr_r, pwr_nxt;
    logic [3:0]          bit_r, bit_nxt, fbits;
    logic [CW-1:0]       chr_r, chr_nxt;
    logic [5:0]          act_r, act_nxt;
    logic                changed;
    logic                entering;

    assign wsel = reg_wr && (reg_ch == 1'(c));
    assign rsel = reg_rd && (reg_ch == 1'(c));

    // Configuration registers; host access works whatever the power state.
    always_comb begin
      top_interrupt_enable_nxt = top_interrupt_enable_r;
      lsren_nxt = lsren_r;
      spen_nxt  = spen_r;
      stsen_nxt = stsen_r;
      operating_config_a_nxt = operating_config_a_r;
      operating_config_b_nxt = operating_config_b_r;
      lcr_nxt   = lcr_r;
      rxto_nxt  = rxto_r;
      hdpx_nxt  = hdpx_r;
      if (wsel) begin
        case (reg_addr)
          usic_pkg::A_TOP_INTERRUPT_ENABLE: top_interrupt_enable_nxt = reg_wdata;
          usic_pkg::A_LSREN: lsren_nxt = reg_wdata;
          usic_pkg::A_SPEN:  spen_nxt  = reg_wdata;
          usic_pkg::A_STSEN: stsen_nxt = reg_wdata;
          usic_pkg::A_OPERATING_CONFIG_A: operating_config_a_nxt = reg_wdata;
          usic_pkg::A_OPERATING_CONFIG_B: operating_config_b_nxt = reg_wdata;
          usic_pkg::A_LCR:   lcr_nxt   = reg_wdata;
          usic_pkg::A_RXTO:  rxto_nxt  = reg_wdata;
          usic_pkg::A_HDPX:  hdpx_nxt  = reg_wdata;
          default: ;
        endcase
      end
    end

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        top_interrupt_enable_r <= usic_pkg::RST_ZERO;
        lsren_r <= usic_pkg::RST_ZERO;
        spen_r  <= usic_pkg::RST_ZERO;
        stsen_r <= usic_pkg::RST_ZERO;
        operating_config_a_r <= usic_pkg::RST_ZERO;
        operating_config_b_r <= usic_pkg::RST_ZERO;
        lcr_r   <= usic_pkg::RST_LCR;
        rxto_r  <= usic_pkg::RST_ZERO;
        hdpx_r  <= usic_pkg::RST_ZERO;
      end else begin
        top_interrupt_enable_r <= top_interrupt_enable_nxt;
        lsren_r <= lsren_nxt;
        spen_r  <= spen_nxt;
        stsen_r <= stsen_nxt;
        operating_config_a_r <= operating_config_a_nxt;
        operating_config_b_r <= operating_config_b_nxt;
        lcr_r   <= lcr_nxt;
        rxto_r  <= rxto_nxt;
        hdpx_r  <= hdpx_nxt;
      end
    end

    // Event registers. A new event in the cycle of a clearing read survives.
    always_comb begin
      sts_view = sts_r & usic_pkg::STS_STICKY;
      sts_view[usic_pkg::STS_CLKRDY] = settled && (pwr_r == usic_pkg::PS_AWAKE);
      lsr_nxt = 8'h00;
      lsr_nxt[5:0] = line_cond[c];
      lsr_nxt[usic_pkg::LSR_CTS] = cts_pin[c];
      sum_nxt = {|(sts_view & stsen_r), |(spc_r & spen_r), |(lsr_r & lsren_r)};
      // Only a rising summary sets the top bit, so a detail still latched
      // after a clearing read does not raise the interrupt again.
      isr_nxt = {top_evt[c], sum_nxt & ~sum_r};
      if (!(rsel && reg_addr == usic_pkg::A_ISR && ch_irq[c])) begin
        isr_nxt = isr_nxt | isr_r;
      end
      spc_nxt = {2'b00, spc_evt[c]};
      if (!(rsel && reg_addr == usic_pkg::A_SPC)) begin
        spc_nxt = spc_nxt | spc_r;
      end
      sts_nxt = 8'h00;
      sts_nxt[3:0] = gpi_evt[c];
      sts_nxt[usic_pkg::STS_TXE] = tx_empty_evt[c];
      sts_nxt[usic_pkg::STS_SLEEP] = entering;
      if (!(rsel && reg_addr == usic_pkg::A_STS)) begin
        sts_nxt = sts_nxt | (sts_r & usic_pkg::STS_STICKY);
      end
    end

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        isr_r <= usic_pkg::RST_ISR;
        lsr_r <= usic_pkg::RST_ZERO;
        spc_r <= usic_pkg::RST_ZERO;
        sts_r <= usic_pkg::RST_STS;
        sum_r <= 3'h0;
      end else begin
        isr_r <= isr_nxt;
        lsr_r <= lsr_nxt;
        spc_r <= spc_nxt;
        sts_r <= sts_nxt;
        sum_r <= sum_nxt;
      end
    end

    assign ch_irq[c] = |(isr_r & top_interrupt_enable_r);

    // Power state with the idle character counter.
    always_comb begin
      act_nxt = {gpio_pin[c], cts_pin[c], rx_pin[c]};
      changed = (act_nxt != act_r);
      fbits   = usic_pkg::FRAME_BASE + {2'b00, lcr_r[1:0]} + {3'b000, lcr_r[usic_pkg::LCR_PAR]}
                + {3'b000, lcr_r[usic_pkg::LCR_STOP]};
      bit_nxt = bit_r;
      chr_nxt = chr_r;
      if (changed || pwr_r != usic_pkg::PS_AWAKE) begin
        bit_nxt = 4'h0;
        chr_nxt = '0;
      end else if (baud_tick[c] && chr_r != CW'(IDLE_CHARS)) begin
        if (bit_r == fbits - 4'h1) begin
          bit_nxt = 4'h0;
          chr_nxt = chr_r + CW'(1);
        end else begin
          bit_nxt = bit_r + 4'h1;
        end
      end
      pwr_nxt = pwr_r;
      unique case (pwr_r)
        usic_pkg::PS_AWAKE: begin
          if (operating_config_a_r[usic_pkg::M1_FORCED]) begin
            pwr_nxt = usic_pkg::PS_FORCED;
          end else if (operating_config_a_r[usic_pkg::M1_AUTO] && fifos_empty[c] && !ch_irq[c]
                       && chr_r == CW'(IDLE_CHARS) && !changed) begin
            pwr_nxt = usic_pkg::PS_AUTO;
          end
        end
        usic_pkg::PS_FORCED: begin
          if (!operating_config_a_r[usic_pkg::M1_FORCED]) begin
            pwr_nxt = usic_pkg::PS_AWAKE;
          end
        end
        usic_pkg::PS_AUTO: begin
          if (operating_config_a_r[usic_pkg::M1_FORCED]) begin
            pwr_nxt = usic_pkg::PS_FORCED;
          end else if (!operating_config_a_r[usic_pkg::M1_AUTO] || changed) begin
            pwr_nxt = usic_pkg::PS_AWAKE;
          end
        end
        default: pwr_nxt = usic_pkg::PS_AWAKE;
      endcase
      entering = (pwr_r == usic_pkg::PS_AWAKE) && (pwr_nxt != usic_pkg::PS_AWAKE);
    end

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        pwr_r <= usic_pkg::PS_AWAKE;
        bit_r <= 4'h0;
        chr_r <= '0;
        act_r <= 6'h00;
      end else begin
        pwr_r <= pwr_nxt;
        bit_r <= bit_nxt;
        chr_r <= chr_nxt;
        act_r <= act_nxt;
      end
    end

    // Both sleep kinds gate the same clock; only this channel is affected.
    assign asleep[c]    = (pwr_r != usic_pkg::PS_AWAKE);
    assign ch_clk_en[c] = ~asleep[c];

    always_comb begin
      rd_ch[c] = 8'h00;
      case (reg_addr)
        usic_pkg::A_DATA:  rd_ch[c] = rx_data[c];
        usic_pkg::A_TOP_INTERRUPT_ENABLE: rd_ch[c] = top_interrupt_enable_r;
        usic_pkg::A_ISR:   rd_ch[c] = isr_r;
        usic_pkg::A_LSREN: rd_ch[c] = lsren_r;
        usic_pkg::A_LSR:   rd_ch[c] = lsr_r;
        usic_pkg::A_SPEN:  rd_ch[c] = spen_r;
        usic_pkg::A_SPC:   rd_ch[c] = spc_r;
        usic_pkg::A_STSEN: rd_ch[c] = stsen_r;
        usic_pkg::A_STS:   rd_ch[c] = sts_view;
        usic_pkg::A_OPERATING_CONFIG_A: rd_ch[c] = operating_config_a_r;
        usic_pkg::A_OPERATING_CONFIG_B: rd_ch[c] = operating_config_b_r;
        usic_pkg::A_LCR:   rd_ch[c] = lcr_r;
        usic_pkg::A_RXTO:  rd_ch[c] = rxto_r;
        usic_pkg::A_HDPX:  rd_ch[c] = hdpx_r;
        default:           rd_ch[c] = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, transmit holding strobe and the shared interrupt pin.

  logic [7:0]               rdata_nxt;
  logic [7:0]               txd_nxt;
  logic [usic_pkg::NCH-1:0] txw_nxt;

  always_comb begin
    rdata_nxt = reg_rdata;
    txd_nxt   = tx_data;
    txw_nxt   = '0;
    if (reg_rd) begin
      rdata_nxt = rd_ch[reg_ch];
    end
    if (reg_wr && reg_addr == usic_pkg::A_DATA) begin
      txd_nxt          = reg_wdata;
      txw_nxt[reg_ch]  = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
      tx_data   <= 8'h00;
      tx_wr     <= '0;
    end else begin
      reg_rdata <= rdata_nxt;
      tx_data   <= txd_nxt;
      tx_wr     <= txw_nxt;
    end
  end

  assign irq_n = ~|ch_irq;

endmodule : usic_top
`default_nettype wire

// ==== rtl/usic_pkg.sv ====
package usic_pkg;

  // Number of serial channels sharing the clock generator.
  localparam int unsigned NCH = 2;

  // Register offsets, one register per channel at each offset.
  localparam logic [3:0] A_DATA   = 4'h0;
  localparam logic [3:0] A_TOP_INTERRUPT_ENABLE  = 4'h1;
  localparam logic [3:0] A_ISR    = 4'h2;
  localparam logic [3:0] A_LSREN  = 4'h3;
  localparam logic [3:0] A_LSR    = 4'h4;
  localparam logic [3:0] A_SPEN   = 4'h5;
  localparam logic [3:0] A_SPC    = 4'h6;
  localparam logic [3:0] A_STSEN  = 4'h7;
  localparam logic [3:0] A_STS    = 4'h8;
  localparam logic [3:0] A_OPERATING_CONFIG_A  = 4'h9;
  localparam logic [3:0] A_OPERATING_CONFIG_B  = 4'hA;
  localparam logic [3:0] A_LCR    = 4'hB;
  localparam logic [3:0] A_RXTO   = 4'hC;
  localparam logic [3:0] A_HDPX   = 4'hD;

  // Field positions.
  localparam int unsigned M1_AUTO   = 6;
  localparam int unsigned M1_FORCED = 5;
  localparam int unsigned STS_TXE   = 7;
  localparam int unsigned STS_SLEEP = 6;
  localparam int unsigned STS_CLKRDY = 5;
  localparam int unsigned LSR_CTS   = 7;
  localparam int unsigned LCR_PAR   = 3;
  localparam int unsigned LCR_STOP  = 2;

  // Reset values.
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ISR  = 8'h60;
  localparam logic [7:0] RST_LCR  = 8'h05;
  localparam logic [7:0] RST_STS  = 8'h80;

  // Bits of the general status register that hold sticky events.
  localparam logic [7:0] STS_STICKY = 8'hCF;

  // Start bit, five data bits and one stop bit: the shortest frame.
  localparam logic [3:0] FRAME_BASE = 4'h7;

  // Per-channel power state.
  typedef enum logic [2:0] {
    PS_AWAKE  = 3'b001,
    PS_FORCED = 3'b010,
    PS_AUTO   = 3'b100
  } usic_pwr_t;

endpackage : usic_pkg

// ==== tb/usic_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module usic_checker (
  // Clock and reset.
  input wire logic       clk,
  input wire logic       resetn,
  // Register port.
  input wire logic       reg_ch,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Pins, levels and outputs.
  input wire logic [1:0] rx_pin,
  input wire logic [1:0] fifos_empty,
  input wire logic [1:0] ch_clk_en,
  input wire logic       shared_clk_en,
  input wire logic       irq_n
);
  ////////////////////////////////////////
  // Shadows of what the host wrote: top enables per channel, sleep bits of channel 0.
  logic [1:0] en_r;
  logic [1:0] en_nxt;
  logic [1:0] m1_r;
  logic [1:0] m1_nxt;
  always_comb begin
    en_nxt = en_r;
    m1_nxt = m1_r;
    if (reg_wr && reg_addr == 4'h1) en_nxt[reg_ch] = |reg_wdata;
    if (reg_wr && reg_addr == 4'h9 && !reg_ch) m1_nxt = reg_wdata[6:5];
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      en_r <= 2'h0;
      m1_r <= 2'h0;
    end else begin
      en_r <= en_nxt;
      m1_r <= m1_nxt;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_shared; shared_clk_en == (ch_clk_en != 2'h0); endproperty
  a_shared: assert property (p_shared) else $error("shared clock enable wrong");
  property p_forced; m1_r[0] && $past(m1_r[0]) |-> !ch_clk_en[0]; endproperty
  a_forced: assert property (p_forced) else $error("forced sleep not gating");
  property p_awake; m1_r == 2'h0 && $past(m1_r) == 2'h0 |-> ch_clk_en[0]; endproperty
  a_awake: assert property (p_awake) else $error("channel asleep while disarmed");
  property p_pinwake; !ch_clk_en[0] && m1_r == 2'h2 && $changed(rx_pin[0]) |-> ##[1:2] ch_clk_en[0]; endproperty
  a_pinwake: assert property (p_pinwake) else $error("pin activity did not wake");
  property p_entry; $fell(ch_clk_en[0]) && !m1_r[0] |-> m1_r[1] && $past(fifos_empty[0]); endproperty
  a_entry: assert property (p_entry) else $error("automatic sleep entered wrongly");
  property p_unmap; reg_rd && reg_addr == 4'hE |=> reg_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_rst; $rose(resetn) |-> irq_n && shared_clk_en && ch_clk_en == 2'h3 && reg_rdata == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("outputs wrong after reset");
  property p_top_interrupt_enable; !irq_n |-> en_r != 2'h0; endproperty
  a_top_interrupt_enable: assert property (p_top_interrupt_enable) else $error("interrupt without top enable");
  c_auto: cover property ($fell(ch_clk_en[0]) && m1_r == 2'h2);
  c_both: cover property (!shared_clk_en);
  c_irq: cover property ($fell(irq_n));
endmodule : usic_checker
bind usic_top usic_checker u_chk (.clk(clk), .resetn(resetn), .reg_ch(reg_ch), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_pin(rx_pin),
  .fifos_empty(fifos_empty), .ch_clk_en(ch_clk_en), .shared_clk_en(shared_clk_en), .irq_n(irq_n));
`default_nettype wire

// ==== tb/usic_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module usic_host (
  // Clock and returned data.
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  // Register requests.
  output logic            reg_ch,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [3:0]      reg_addr,
  output logic [7:0]      reg_wdata
);
  initial begin
    reg_ch = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
  end
  // Idle address and data show the inverse of the last value so stale contents never help.
  task automatic xfer(input logic ch, input logic w, input logic [3:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clk);
    #1;
    reg_ch = ch;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    q = reg_rdata;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : xfer
  task automatic poll(output logic ok);
    logic [7:0] q;
    ok = 1'b0;
    for (int i = 0; i < 16 && !ok; i++) begin
      xfer(1'b0, 1'b0, 4'hB, 8'h00, q);
      ok = (q === 8'h05);
    end
  endtask : poll
endmodule : usic_host
`default_nettype wire

// ==== tb/uart_sleep_and_interrupt_control_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module uart_sleep_and_interrupt_control_test;
  logic            clk = 1'b0;
  logic            resetn = 1'b0;
  logic            reg_ch, reg_wr, reg_rd;
  logic [3:0]      reg_addr;
  logic [7:0]      reg_wdata, reg_rdata, tx_data, q;
  logic [1:0]      tx_wr, ch_clk_en;
  logic            shared_clk_en, irq_n;
  logic [1:0][7:0] rx_data = {8'hC3, 8'h3C};
  logic [1:0]      rx_pin = 2'h0, cts_pin = 2'h0, tx_empty_evt = 2'h0, fifos_empty = 2'h0, baud_tick = 2'h0;
  logic [1:0][3:0] gpio_pin = 8'h00, gpi_evt = 8'h00;
  logic [1:0][4:0] top_evt = 10'h000;
  logic [1:0][5:0] line_cond = 12'h000, spc_evt = 12'h000;
  logic [1:0]      bcnt = 2'h0;
  int              miscompares = 0;
  int              tests_run = 0;

  usic_top #(.IDLE_CHARS(4), .SETTLE_CYC(8)) u_dut (.clk(clk), .resetn(resetn), .reg_ch(reg_ch),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .tx_wr(tx_wr), .tx_data(tx_data), .rx_data(rx_data), .rx_pin(rx_pin), .cts_pin(cts_pin),
    .gpio_pin(gpio_pin), .top_evt(top_evt), .line_cond(line_cond), .spc_evt(spc_evt), .gpi_evt(gpi_evt),
    .tx_empty_evt(tx_empty_evt), .fifos_empty(fifos_empty), .baud_tick(baud_tick),
    .ch_clk_en(ch_clk_en), .shared_clk_en(shared_clk_en), .irq_n(irq_n));
  usic_host u_host (.clk(clk), .reg_rdata(reg_rdata), .reg_ch(reg_ch), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  always #5 clk = ~clk;
  // One bit time every four clocks keeps a character at 36 clocks with the reset frame format.
  always @(posedge clk) begin
    #1;
    baud_tick = {2{bcnt == 2'h3}};
    bcnt = bcnt + 2'h1;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(input logic ch, input logic [3:0] a, input logic [7:0] d);
    u_host.xfer(ch, 1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic ch, input logic [3:0] a);
    u_host.xfer(ch, 1'b0, a, 8'h00, q);
  endtask : rd
  task automatic wait_clk(input logic lvl, output int n);
    n = 0;
    while (ch_clk_en[0] !== lvl && n < 400) begin
      cyc(1);
      n++;
    end
    if (n == 400) begin
      miscompares++;
      end_sim();
    end
  endtask : wait_clk
  function automatic logic [7:0] rv(input int a);
    return (a == 2) ? 8'h60 : (a == 11) ? 8'h05 : 8'h00;
  endfunction : rv
  ////////////////////////////////////////
  task automatic t_reset;
    logic ok;
    chk({7'h00, irq_n}, 8'h01);
    rd(1'b0, 4'h8);
    chk(q, 8'h80);
    u_host.poll(ok);
    chk({7'h00, ok}, 8'h01);
    for (int a = 1; a < 16; a++) begin
      if (a != 8) begin
        rd(1'b0, 4'(a));
        chk(q, rv(a));
        wr(1'b0, 4'(a), 8'h5A);
        rd(1'b0, 4'(a));
        chk(q, ((a % 2 == 1 && a < 8) || (a > 8 && a < 14)) ? 8'h5A : rv(a));
        wr(1'b0, 4'(a), rv(a));
      end
    end
  endtask : t_reset
  task automatic t_forced;
    wr(1'b0, 4'h9, 8'h20);
    cyc(1);
    chk({5'h00, shared_clk_en, ch_clk_en}, 8'h06);
    wr(1'b0, 4'h0, 8'hA7);
    chk({tx_wr, tx_data[5:0]}, 8'h67);
    rd(1'b0, 4'h0);
    chk(q, 8'h3C);
    wr(1'b1, 4'h9, 8'h20);
    cyc(1);
    chk({5'h00, shared_clk_en, ch_clk_en}, 8'h00);
    wr(1'b0, 4'h9, 8'h00);
    wr(1'b1, 4'h9, 8'h00);
    cyc(1);
    chk({5'h00, shared_clk_en, ch_clk_en}, 8'h07);
    rd(1'b1, 4'h8);
    chk(q, 8'hC0);
    cyc(10);
    rd(1'b1, 4'h8);
    chk(q, 8'h20);
  endtask : t_forced
  task automatic t_auto;
    int n;
    wr(1'b0, 4'h9, 8'h40);
    cyc(200);
    chk({7'h00, ch_clk_en[0]}, 8'h01);
    fifos_empty = 2'h3;
    rx_pin[0] = ~rx_pin[0];
    wait_clk(1'b0, n);
    chk({7'h00, n >= 136 && n <= 152}, 8'h01);
    for (int k = 0; k < 3; k++) begin
      case (k)
        0: gpio_pin[0][2] = ~gpio_pin[0][2];
        1: cts_pin[0] = ~cts_pin[0];
        default: rx_pin[0] = ~rx_pin[0];
      endcase
      cyc(2);
      chk({7'h00, ch_clk_en[0]}, 8'h01);
      wait_clk(1'b0, n);
    end
    wr(1'b1, 4'h9, 8'h20);
    cyc(1);
    chk({7'h00, shared_clk_en}, 8'h00);
    wr(1'b1, 4'h9, 8'h00);
    wr(1'b0, 4'h9, 8'h00);
    cyc(1);
    chk({7'h00, ch_clk_en[0]}, 8'h01);
    cyc(300);
    chk({7'h00, ch_clk_en[0]}, 8'h01);
  endtask : t_auto
  task automatic t_irq;
    logic [3:0] den[3] = '{4'h3, 4'h5, 4'h7};
    wr(1'b1, 4'h1, 8'h60);
    chk({7'h00, irq_n}, 8'h00);
    rd(1'b1, 4'h2);
    chk({q[6:0], irq_n}, 8'hC1);
    for (int k = 0; k < 3; k++) begin
      wr(1'b1, 4'h1, 8'h01 << k);
      wr(1'b1, den[k], 8'h01);
      case (k)
        0: line_cond[1] = 6'h01;
        1: spc_evt[1] = 6'h01;
        default: gpi_evt[1] = 4'h1;
      endcase
      cyc(1);
      spc_evt[1] = 6'h00;
      gpi_evt[1] = 4'h0;
      cyc(2);
      chk({7'h00, irq_n}, 8'h00);
      rd(1'b1, 4'h2);
      chk(q, 8'h01 << k);
      cyc(3);
      chk({7'h00, irq_n}, 8'h01);
      rd(1'b1, den[k] + 4'h1);
      chk(q & 8'h0F, 8'h01);
      rd(1'b1, den[k] + 4'h1);
      chk(q & 8'h0F, {7'h00, k == 0});
      line_cond[1] = 6'h00;
    end
    wr(1'b1, 4'h1, 8'h00);
    spc_evt[1] = 6'h01;
    cyc(1);
    spc_evt[1] = 6'h00;
    cyc(3);
    chk({7'h00, irq_n}, 8'h01);
    rd(1'b1, 4'h2);
    chk(q, 8'h02);
    wr(1'b1, 4'h1, 8'h08);
    top_evt[1][0] = 1'b1;
    cyc(1);
    top_evt[1][0] = 1'b0;
    chk({7'h00, irq_n}, 8'h00);
    rd(1'b1, 4'h2);
    chk({q[6:0], irq_n}, 8'h15);
    wr(1'b1, 4'h1, 8'h00);
  endtask : t_irq
  // A second shutdown in mid-run must wipe what the host set up before it.
  task automatic t_rerun;
    logic ok;
    wr(1'b1, 4'h9, 8'h20);
    wr(1'b0, 4'hB, 8'h03);
    wr(1'b0, 4'h0, 8'h99);
    resetn = 1'b0;
    cyc(1);
    chk({4'h0, shared_clk_en, ch_clk_en, irq_n}, 8'h0F);
    chk(reg_rdata, 8'h00);
    chk(tx_data, 8'h00);
    cyc(4);
    resetn = 1'b1;
    u_host.poll(ok);
    chk({7'h00, ok}, 8'h01);
    rd(1'b1, 4'h9);
    chk(q, 8'h00);
    rd(1'b1, 4'h8);
    chk(q, 8'h80);
  endtask : t_rerun
  ////////////////////////////////////////
  initial begin
    #900000;
    miscompares++;
    end_sim();
  end
  initial begin
    cyc(2);
    wr(1'b0, 4'hC, 8'hFF);
    cyc(1);
    resetn = 1'b1;
    t_reset();
    t_forced();
    t_auto();
    t_irq();
    t_rerun();
    end_sim();
  end
endmodule : uart_sleep_and_interrupt_control_test
`default_nettype wire
